/* common/csap_pkg.sv */
/*
 * Constants for the CPU-side access port of the CAN controller:
 * special function register addresses, internal register addresses
 * and the bounds of the indirect address map.
 * Assumes an 8-bit SFR bus and an 8-bit internal controller address.
 */
package csap_pkg;
    localparam int AW = 8;
    localparam int DW = 8;

    // special function register decode addresses
    localparam logic [7:0] SFR_STA_IEN = 8'hC0;
    localparam logic [7:0] SFR_PTR     = 8'hC1;
    localparam logic [7:0] SFR_DAT     = 8'hC2;
    localparam logic [7:0] SFR_IRQ_CMD = 8'hC3;
    localparam logic [7:0] SFR_MODE    = 8'hC4;

    // internal controller addresses
    localparam logic [7:0] CA_MODE     = 8'h00;
    localparam logic [7:0] CA_COMMAND  = 8'h01;
    localparam logic [7:0] CA_STATUS   = 8'h02;
    localparam logic [7:0] CA_IRQ      = 8'h03;
    localparam logic [7:0] CA_IRQ_EN   = 8'h04;
    localparam logic [7:0] CA_RX_LEVEL = 8'h05;
    localparam logic [7:0] CA_BT0      = 8'h06;
    localparam logic [7:0] CA_BT1      = 8'h07;
    localparam logic [7:0] CA_NOTE8    = 8'h08;
    localparam logic [7:0] CA_RXB_SA   = 8'h0A;
    localparam logic [7:0] CA_EWL      = 8'h0D;
    localparam logic [7:0] CA_RXERR    = 8'h0E;
    localparam logic [7:0] CA_TXERR    = 8'h0F;
    localparam logic [7:0] CA_RSV_LO   = 8'h10;
    localparam logic [7:0] CA_RSV_HI   = 8'h1C;
    localparam logic [7:0] CA_ACF_MODE = 8'h1D;
    localparam logic [7:0] CA_AUTOINC  = 8'h20;
    localparam logic [7:0] CA_RSV2_LO  = 8'h40;
    localparam logic [7:0] CA_RX_LO    = 8'h60;
    localparam logic [7:0] CA_RSV3_LO  = 8'h6D;
    localparam logic [7:0] CA_TX_BASE  = 8'h70;
    localparam logic [7:0] CA_FIFO     = 8'h80;

    localparam logic [7:0] PTR_RESET   = 8'h00;
    localparam logic [7:0] PTR_STEP    = 8'h01;
    localparam logic [7:0] DATA_ZERO   = 8'h00;
endpackage

/* core/csap_access_qual.sv */
/*
 * Access qualifier: decides from the internal address, the direction
 * and the controller's reset-mode level whether an access reaches a
 * real location. Purely combinational.
 * Assumes reset_mode comes from the controller on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module csap_access_qual
    import csap_pkg::*;
(
    // address and mode
    input  wire logic [7:0] addr,
    input  wire logic       reset_mode,
    // verdicts
    output logic            rd_ok,
    output logic            wr_ok
);
    always_comb begin
        // reserved and write-only spots read back as zero
        rd_ok = 1'b1;
        if (addr == CA_COMMAND) begin
            rd_ok = 1'b0;
        end
        if (addr == CA_NOTE8 && reset_mode) begin
            rd_ok = 1'b0;
        end
        if ((addr >= CA_RSV_LO && addr <= CA_RSV_HI)
            || (addr >= CA_RSV2_LO && addr < CA_RX_LO)
            || (addr >= CA_RSV3_LO && addr < CA_TX_BASE)) begin
            rd_ok = 1'b0;
        end

        wr_ok = 1'b0;
        case (addr)
            CA_MODE, CA_COMMAND, CA_IRQ_EN, CA_RX_LEVEL, CA_EWL:
                wr_ok = 1'b1;
            CA_BT0, CA_BT1, CA_RXERR, CA_TXERR, CA_ACF_MODE:
                wr_ok = reset_mode;
            CA_RXB_SA:
                wr_ok = 1'b0;
            default: begin
                if (addr > CA_ACF_MODE && addr < CA_RSV2_LO) begin
                    wr_ok = 1'b1;
                end else if (addr >= CA_RX_LO && addr < CA_RSV3_LO) begin
                    wr_ok = reset_mode;
                end else if (addr >= CA_TX_BASE) begin
                    // tx buffer and fifo ram window upward
                    wr_ok = 1'b1;
                end
            end
        endcase
    end
endmodule
`default_nettype wire

/* core/csap_port.sv */
/*
 * SFR access port into the CAN controller's internal register space.
 * Five SFRs: pointer, data window and three direct-mapped registers.
 * Assumes the controller answers CAN_RDATA in the cycle CAN_RD is high,
 * on the same clock, and CPU issues one SFR read or write per cycle.
 */
`timescale 1ns/100ps
`default_nettype none
// Operation
// - five SFRs reach the whole controller space, indirect pointer for the rest.
// - pointer SFR is read/write and selects the data-window target.
// - pointer at 32 or more increments after every data-window access.
// - auto-increment from FFh wraps the pointer to 00h.
// - pointer below 32 stays unchanged on data-window access.
// - data-window read returns, write updates, the pointed register.
// - mode SFR maps directly to internal address 0.
// - status SFR reads address 2, writes address 4.
// - control SFR reads address 3, writes address 1.
// - SFR decode at C0, C1, C2, C3 and C4.
// - fifo ram is mapped from internal address 128 upward.
// - internal decode depends on reset mode and access direction.
// - address 10 is readable in both modes, never written.
module csap_port
    import csap_pkg::*;
(
    // clock and control
    input  wire logic          MCLK,
    input  wire logic          RESET,
    input  wire logic          CE,
    // cpu sfr bus
    input  wire logic [7:0]    SFR_ADDR,
    input  wire logic          SFR_RD,
    input  wire logic          SFR_WR,
    input  wire logic [DW-1:0] SFR_WDATA,
    output logic      [DW-1:0] SFR_RDATA,
    output logic               SFR_RVALID,
    // controller register bus
    output logic      [AW-1:0] CAN_ADDR,
    output logic               CAN_RD,
    output logic               CAN_WR,
    output logic      [DW-1:0] CAN_WDATA,
    input  wire logic [DW-1:0] CAN_RDATA,
    input  wire logic          CAN_RESET_MODE
);
    typedef struct packed {
        logic [AW-1:0] ptr;
        logic [AW-1:0] can_addr;
        logic          can_rd;
        logic          can_wr;
        logic [DW-1:0] can_wdata;
        logic          rd_pend;
        logic          rd_local;
        logic [DW-1:0] local_data;
        logic [DW-1:0] rdata;
        logic          rvalid;
    } csap_state_type;

    csap_state_type st_ff;
    csap_state_type nxt_st;

    logic          hit;
    logic          dir_wr;
    logic [AW-1:0] tgt;
    logic          rd_ok;
    logic          wr_ok;

    function automatic logic is_port_sfr(input logic [7:0] a);
        is_port_sfr = (a == SFR_STA_IEN) || (a == SFR_PTR)
                   || (a == SFR_DAT) || (a == SFR_IRQ_CMD)
                   || (a == SFR_MODE);
    endfunction

    assign hit    = CE && (SFR_RD || SFR_WR) && is_port_sfr(SFR_ADDR);
    assign dir_wr = SFR_WR;

    // internal target of the current SFR access
    always_comb begin
        case (SFR_ADDR)
            SFR_MODE:    tgt = CA_MODE;
            SFR_STA_IEN: tgt = dir_wr ? CA_IRQ_EN : CA_STATUS;
            SFR_IRQ_CMD: tgt = dir_wr ? CA_COMMAND : CA_IRQ;
            default:     tgt = st_ff.ptr;
        endcase
    end

    csap_access_qual u_qual (
        .addr       (tgt),
        .reset_mode (CAN_RESET_MODE),
        .rd_ok      (rd_ok),
        .wr_ok      (wr_ok)
    );

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.can_rd = 1'b0;
        nxt_st.can_wr = 1'b0;
        nxt_st.rvalid = 1'b0;
        nxt_st.rd_pend = 1'b0;

        // second stage of a read: capture answer from controller
        if (st_ff.rd_pend) begin
            nxt_st.rvalid = 1'b1;
            if (st_ff.rd_local) begin
                nxt_st.rdata = st_ff.local_data;
            end else if (st_ff.can_rd) begin
                nxt_st.rdata = CAN_RDATA;
            end else begin
                nxt_st.rdata = DATA_ZERO;
            end
        end

        if (hit) begin
            nxt_st.can_addr = tgt;
            nxt_st.rd_local = 1'b0;
            if (SFR_ADDR == SFR_PTR) begin
                if (dir_wr) begin
                    nxt_st.ptr = SFR_WDATA;
                end else begin
                    nxt_st.rd_pend    = 1'b1;
                    nxt_st.rd_local   = 1'b1;
                    nxt_st.local_data = st_ff.ptr;
                end
            end else begin
                if (dir_wr) begin
                    nxt_st.can_wr    = wr_ok;
                    nxt_st.can_wdata = SFR_WDATA;
                end else begin
                    nxt_st.can_rd  = rd_ok;
                    nxt_st.rd_pend = 1'b1;
                end
                // stepping here means the next access already sees it
                if (SFR_ADDR == SFR_DAT && st_ff.ptr >= CA_AUTOINC) begin
                    nxt_st.ptr = st_ff.ptr + PTR_STEP;
                end
                // low registers stay put so software can poll them
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st_ff <= '0;
        end else if (CE) begin
            st_ff <= nxt_st;
        end
    end

    assign SFR_RDATA  = st_ff.rdata;
    assign SFR_RVALID = st_ff.rvalid;
    assign CAN_ADDR   = st_ff.can_addr;
    assign CAN_RD     = st_ff.can_rd;
    assign CAN_WR     = st_ff.can_wr;
    assign CAN_WDATA  = st_ff.can_wdata;

    logic dat_acc;
    assign dat_acc = hit && SFR_ADDR == SFR_DAT;

    chk_ptr_autoinc: assert property (
        @(posedge MCLK) disable iff (RESET)
        dat_acc && st_ff.ptr >= CA_AUTOINC
        |=> st_ff.ptr == $past(st_ff.ptr) + PTR_STEP)
        else $error("pointer did not step after data access");

    chk_ptr_hold_low: assert property (
        @(posedge MCLK) disable iff (RESET)
        dat_acc && st_ff.ptr < CA_AUTOINC |=> $stable(st_ff.ptr))
        else $error("low pointer moved on data access");

    chk_ptr_wrap_zero: assert property (
        @(posedge MCLK) disable iff (RESET)
        dat_acc && st_ff.ptr == '1 |=> st_ff.ptr == PTR_RESET)
        else $error("pointer failed to wrap to zero");

    chk_ptr_write_load: assert property (
        @(posedge MCLK) disable iff (RESET)
        hit && SFR_WR && SFR_ADDR == SFR_PTR
        |=> st_ff.ptr == $past(SFR_WDATA))
        else $error("pointer write not taken");

    chk_dat_target: assert property (
        @(posedge MCLK) disable iff (RESET)
        dat_acc |=> CAN_ADDR == $past(st_ff.ptr))
        else $error("data window hit wrong address");

    chk_mode_direct: assert property (
        @(posedge MCLK) disable iff (RESET)
        hit && SFR_ADDR == SFR_MODE |=> CAN_ADDR == CA_MODE)
        else $error("mode sfr not routed to address zero");

    chk_sta_split: assert property (
        @(posedge MCLK) disable iff (RESET)
        hit && SFR_ADDR == SFR_STA_IEN
        |=> CAN_ADDR == ($past(SFR_WR) ? CA_IRQ_EN : CA_STATUS)
            && (CAN_RD || CAN_WR))
        else $error("status sfr routed wrongly");

    chk_con_split: assert property (
        @(posedge MCLK) disable iff (RESET)
        hit && SFR_ADDR == SFR_IRQ_CMD
        |=> CAN_ADDR == ($past(SFR_WR) ? CA_COMMAND : CA_IRQ)
            && (CAN_RD != CAN_WR))
        else $error("control sfr routed wrongly");

    chk_rxsa_nowrite: assert property (
        @(posedge MCLK) disable iff (RESET)
        CAN_WR |-> CAN_ADDR != CA_RXB_SA)
        else $error("write reached rx buffer start address");

    chk_ptr_reset: assert property (
        @(posedge MCLK) RESET |=> st_ff.ptr == PTR_RESET)
        else $error("pointer not cleared by reset");

    chk_read_answer: assert property (
        @(posedge MCLK) disable iff (RESET)
        (hit && SFR_RD) ##1 CE |=> SFR_RVALID)
        else $error("read answer missing after two cycles");

    chk_cmd_read_zero: assert property (
        @(posedge MCLK) disable iff (RESET)
        dat_acc && SFR_RD && st_ff.ptr == CA_COMMAND |=> !CAN_RD)
        else $error("write-only command address was read");

    chk_rxsa_readable: assert property (
        @(posedge MCLK) disable iff (RESET)
        dat_acc && SFR_RD && st_ff.ptr == CA_RXB_SA |=> CAN_RD)
        else $error("rx buffer start address not read");

    // a low enable must hold every register, strobes included
    chk_ce_freeze: assert property (
        @(posedge MCLK) disable iff (RESET)
        !CE |=> $stable(st_ff))
        else $error("state moved while clock enable was low");
endmodule
`default_nettype wire

/* tb/csap_ctrl_model.sv */
/*
 * Stand-in for the controller's internal register space: 256 bytes,
 * read combinationally while CAN_RD is high, written on CAN_WR.
 * Assumes the port drives registered strobes on MCLK.
 */
`timescale 1ns/100ps
`default_nettype none
module csap_ctrl_model (
    // clock
    input  wire logic       MCLK,
    // register bus
    input  wire logic [7:0] CAN_ADDR,
    input  wire logic       CAN_RD,
    input  wire logic       CAN_WR,
    input  wire logic [7:0] CAN_WDATA,
    output logic      [7:0] CAN_RDATA
);
    logic [7:0] mem [256];
    logic [7:0] last;
    initial begin
        last = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
    end
    // idle bus shows the inverse, so stale data never passes as valid
    assign CAN_RDATA = CAN_RD ? mem[CAN_ADDR] : ~last;
    always @(posedge MCLK) begin
        if (CAN_RD)
            last <= mem[CAN_ADDR];
        if (CAN_WR)
            mem[CAN_ADDR] <= CAN_WDATA;
    end
endmodule
`default_nettype wire

/* tb/csap_port_tb.sv */
/*
 * Self-checking bench for the SFR access port: driver queues expected
 * read data, a monitor compares it when SFR_RVALID appears.
 * Assumes the controller stand-in csap_ctrl_model behind the port.
 */
`timescale 1ns/100ps
`default_nettype none
module csap_port_tb;
    import csap_pkg::*;
    logic       MCLK = 1'b0;
    logic       RESET = 1'b1;
    logic [7:0] SFR_ADDR = 8'h00;
    logic       SFR_RD = 1'b0;
    logic       SFR_WR = 1'b0;
    logic [7:0] SFR_WDATA = 8'h00;
    logic       CAN_RESET_MODE = 1'b0;
    logic       CE = 1'b1;
    logic [7:0] SFR_RDATA;
    logic       SFR_RVALID;
    logic [7:0] CAN_ADDR;
    logic       CAN_RD;
    logic       CAN_WR;
    logic [7:0] CAN_WDATA;
    logic [7:0] CAN_RDATA;
    logic [7:0] expq [$];
    logic [7:0] shadow [256];
    int         mismatches = 0;
    int         checked = 0;
    int         cycles = 0;
    logic [7:0] d;

    csap_port dut_u (.MCLK(MCLK), .RESET(RESET), .CE(CE),
        .SFR_ADDR(SFR_ADDR), .SFR_RD(SFR_RD), .SFR_WR(SFR_WR),
        .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
        .SFR_RVALID(SFR_RVALID), .CAN_ADDR(CAN_ADDR), .CAN_RD(CAN_RD),
        .CAN_WR(CAN_WR), .CAN_WDATA(CAN_WDATA), .CAN_RDATA(CAN_RDATA),
        .CAN_RESET_MODE(CAN_RESET_MODE));
    csap_ctrl_model mdl_u (.MCLK(MCLK), .CAN_ADDR(CAN_ADDR),
        .CAN_RD(CAN_RD), .CAN_WR(CAN_WR), .CAN_WDATA(CAN_WDATA),
        .CAN_RDATA(CAN_RDATA));

    initial begin
        forever #10 MCLK = ~MCLK;
    end

    task automatic end_sim();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one access per cycle; the next call overwrites, so no gaps needed
    task automatic acc(input logic r, input logic w, input logic [7:0] a,
                       input logic [7:0] v);
        SFR_RD <= r;
        SFR_WR <= w;
        SFR_ADDR <= a;
        SFR_WDATA <= v;
        @(posedge MCLK);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        acc(1'b0, 1'b1, a, v);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        acc(1'b1, 1'b0, a, 8'h00);
    endtask

    task automatic wrs(input logic [7:0] a, input int ca);
        logic [7:0] v;
        v = 8'($urandom);
        shadow[ca] = v;
        wr(a, v);
    endtask

    task automatic note(input string s);
        SFR_RD <= 1'b0;
        SFR_WR <= 1'b0;
        repeat (4) @(posedge MCLK);
        $display("test %s done", s);
    endtask

    always @(posedge MCLK) begin
        if (SFR_RVALID === 1'b1) begin
            if (expq.size() == 0)
                cmp(8'hEE, 8'h00);
            else
                cmp(SFR_RDATA, expq.pop_front());
        end
    end

    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(32'h11730929));
        for (int i = 0; i < 256; i++) begin
            shadow[i] = 8'(i) ^ 8'hA5;
        end
        repeat (8) @(posedge MCLK);
        RESET <= 1'b0;
        @(posedge MCLK);
        rd(SFR_PTR, PTR_RESET);
        note("reset");
        wrs(SFR_MODE, 0);
        wrs(SFR_STA_IEN, 4);
        wrs(SFR_IRQ_CMD, 1);
        rd(SFR_MODE, shadow[0]);
        rd(SFR_STA_IEN, shadow[2]);
        rd(SFR_IRQ_CMD, shadow[3]);
        note("direct");
        wr(SFR_PTR, CA_TX_BASE);
        for (int i = 0; i < 13; i++) begin
            wrs(SFR_DAT, 112 + i);
        end
        rd(SFR_PTR, 8'(CA_TX_BASE + 13));
        wr(SFR_PTR, CA_TX_BASE);
        for (int i = 0; i < 13; i++) begin
            rd(SFR_DAT, shadow[112 + i]);
        end
        rd(SFR_PTR, 8'(CA_TX_BASE + 13));
        note("stream");
        wr(SFR_PTR, CA_RX_LEVEL);
        rd(SFR_DAT, shadow[5]);
        rd(SFR_DAT, shadow[5]);
        rd(SFR_PTR, CA_RX_LEVEL);
        note("low poll");
        wr(SFR_PTR, 8'hFF);
        wrs(SFR_DAT, 255);
        rd(SFR_PTR, PTR_RESET);
        wr(SFR_PTR, CA_FIFO);
        wrs(SFR_DAT, 128);
        wr(SFR_PTR, CA_FIFO);
        rd(SFR_DAT, shadow[128]);
        rd(SFR_PTR, 8'h81);
        note("wrap and fifo");
        for (int m = 0; m < 2; m++) begin
            CAN_RESET_MODE <= m[0];
            wr(SFR_PTR, CA_RXB_SA);
            wr(SFR_DAT, 8'($urandom));
            rd(SFR_DAT, shadow[10]);
            wr(SFR_PTR, CA_COMMAND);
            rd(SFR_DAT, DATA_ZERO);
            wr(SFR_PTR, CA_NOTE8);
            rd(SFR_DAT, (m == 1) ? DATA_ZERO : shadow[8]);
            wr(SFR_PTR, CA_RSV_LO);
            wr(SFR_DAT, 8'($urandom));
            rd(SFR_DAT, DATA_ZERO);
            wr(SFR_PTR, CA_BT0);
            d = 8'($urandom);
            if (m == 1)
                shadow[6] = d;
            wr(SFR_DAT, d);
            rd(SFR_DAT, shadow[6]);
        end
        note("mode decode");
        acc(1'b1, 1'b0, 8'hC5, 8'h00);
        acc(1'b0, 1'b1, 8'hC5, 8'($urandom));
        note("unmapped");
        // a write under a low enable must be lost; a read spans the freeze
        CE <= 1'b0;
        wr(SFR_PTR, 8'h33);
        CE <= 1'b1;
        rd(SFR_DAT, shadow[6]);
        CE <= 1'b0;
        SFR_RD <= 1'b0;
        repeat (3) @(posedge MCLK);
        CE <= 1'b1;
        rd(SFR_PTR, CA_BT0);
        note("freeze");
        cmp(8'(expq.size()), 8'h00);
        for (int i = 0; i < 256; i++) begin
            cmp(mdl_u.mem[i], shadow[i]);
        end
        end_sim();
    end
endmodule
`default_nettype wire
